// ### rtl/scc_top.sv
// standalone pin control of a two coil chopper with register access
// assumes pins synchronous to sys_clk and an AHB-Lite master with
// hready fed back from hreadyout
`timescale 1ns/1ps
module scc_top #(
  parameter logic [15:0] CHOP_PERIOD = 16'(scc_pkg::SCC_CHOP_CYCLES)
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic interface_select,
  input wire logic bridge_a_mixed_decay_n,
  input wire logic bridge_b_mixed_decay_n,
  input wire logic bridge_a_polarity,
  input wire logic bridge_b_polarity,
  input wire logic sleep_request,
  input wire logic sense_a_input,
  input wire logic sense_b_input,
  input wire logic supply_threshold_trip,
  input wire logic overtemp_trip,
  output scc_pkg::scc_gates_type coil_a_gates,
  output scc_pkg::scc_gates_type coil_b_gates,
  output logic fault_output,
  output logic fault_output_oe,
  output logic standby_active,
  output logic [3:0] dac_code_a,
  output logic [3:0] dac_code_b
);
  import scc_pkg::*;

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  function automatic scc_reg_type reg_decode(input logic [31:0] addr);
    scc_reg_type r;
    r = SCC_R_NONE;
    if (addr[31:8] == 24'h000000) begin
      case (addr[7:0])
        SCC_OFS_PERIOD: r = SCC_R_PERIOD;
        SCC_OFS_FAST: r = SCC_R_FAST;
        SCC_OFS_SERIAL: r = SCC_R_SERIAL;
        SCC_OFS_STATUS: r = SCC_R_STATUS;
        default: r = SCC_R_NONE;
      endcase
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  localparam int NSYNC = 6;
  localparam int I_POL_A = 0;
  localparam int I_POL_B = 1;
  localparam int I_MD_A = 2;
  localparam int I_MD_B = 3;
  localparam int I_SLEEP = 4;
  localparam int I_SEL = 5;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic pol_prev_a;
  logic pol_prev_b;
  logic restart_a;
  logic restart_b;
  logic standalone;
  logic sleep_s;
  logic mix_a;
  logic mix_b;

  logic [15:0] period_reg;
  logic [15:0] fast_reg;
  logic [9:0] serial_reg;
  logic [15:0] chop_cnt;
  logic [15:0] last_cnt;
  logic start_a;
  logic start_b;

  logic ocp_flag;
  logic ot_flag;
  logic next_ocp;
  logic next_ot;
  logic hold_off;
  scc_phase_type phase_a;
  scc_phase_type phase_b;

  logic take;
  logic dp_write;
  scc_reg_type dp_reg;
  scc_reg_type ap_reg;
  logic [31:0] status_word;

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  assign pin_raw = {interface_select, sleep_request, bridge_b_mixed_decay_n,
                    bridge_a_mixed_decay_n, bridge_b_polarity, bridge_a_polarity};

  // second stage feeds all logic; first stage is read by nothing else
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pol_prev_a <= 1'b0;
      pol_prev_b <= 1'b0;
    end else begin
      pol_prev_a <= sync2[I_POL_A];
      pol_prev_b <= sync2[I_POL_B];
    end
  end

  assign restart_a = sync2[I_POL_A] ^ pol_prev_a;
  assign restart_b = sync2[I_POL_B] ^ pol_prev_b;
  assign standalone = !sync2[I_SEL];
  assign sleep_s = sync2[I_SLEEP];

  // pins are active low enables; serial bits are active high
  assign mix_a = standalone ? !sync2[I_MD_A] : serial_reg[SCC_SR_MIX_A];
  assign mix_b = standalone ? !sync2[I_MD_B] : serial_reg[SCC_SR_MIX_B];

  // --------------------------------------------------------------
  // chopper time base
  // --------------------------------------------------------------
  // periods below two cycles are not meaningful; treated as two
  assign last_cnt = (period_reg < 16'h0002) ? 16'h0001 : 16'(period_reg - 16'h0001);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chop_cnt <= 16'h0000;
    end else if (chop_cnt >= last_cnt) begin
      chop_cnt <= 16'h0000;
    end else begin
      chop_cnt <= 16'(chop_cnt + 16'h0001);
    end
  end

  // bridge B starts half a period after bridge A
  assign start_a = (chop_cnt == 16'h0000);
  assign start_b = (chop_cnt == 16'(({1'b0, last_cnt} + 17'h00001) >> 1));

  // --------------------------------------------------------------
  // error latches and standby
  // --------------------------------------------------------------
  // a new event wins over the clearing sleep level
  assign next_ocp = supply_threshold_trip | (ocp_flag & !sleep_s);
  assign next_ot = overtemp_trip | (ot_flag & !sleep_s);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ocp_flag <= 1'b0;
      ot_flag <= 1'b0;
      fault_output <= 1'b0;
    end else begin
      ocp_flag <= next_ocp;
      ot_flag <= next_ot;
      fault_output <= next_ocp | next_ot;
    end
  end

  // the pin never floats while the block is in standalone use
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fault_output_oe <= 1'b1;
    end else begin
      fault_output_oe <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      standby_active <= 1'b0;
    end else begin
      standby_active <= sleep_s;
    end
  end

  // gates drop in the same edge that standby is entered
  assign hold_off = sleep_s | ocp_flag | ot_flag;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dac_code_a <= SCC_DAC_FULL;
      dac_code_b <= SCC_DAC_FULL;
    end else if (standalone) begin
      dac_code_a <= SCC_DAC_FULL;
      dac_code_b <= SCC_DAC_FULL;
    end else begin
      dac_code_a <= serial_reg[SCC_SR_DAC_A +: 4];
      dac_code_b <= serial_reg[SCC_SR_DAC_B +: 4];
    end
  end

  // --------------------------------------------------------------
  // bridges
  // --------------------------------------------------------------
  scc_bridge u_bridge_a (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(start_a),
    .restart(restart_a),
    .polarity(sync2[I_POL_A]),
    .mixed_en(mix_a),
    .sense_trip(sense_a_input),
    .hold_off(hold_off),
    .fast_len(fast_reg),
    .gates(coil_a_gates),
    .phase(phase_a)
  );

  scc_bridge u_bridge_b (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(start_b),
    .restart(restart_b),
    .polarity(sync2[I_POL_B]),
    .mixed_en(mix_b),
    .sense_trip(sense_b_input),
    .hold_off(hold_off),
    .fast_len(fast_reg),
    .gates(coil_b_gates),
    .phase(phase_b)
  );

  // --------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------
  assign take = hsel && htrans[1] && hready;
  assign ap_reg = reg_decode(haddr);

  always_comb begin
    status_word = 32'h00000000;
    status_word[SCC_ST_FAULT] = fault_output;
    status_word[SCC_ST_OCP] = ocp_flag;
    status_word[SCC_ST_OT] = ot_flag;
    status_word[SCC_ST_STBY] = standby_active;
    status_word[SCC_ST_ALONE] = standalone;
    status_word[SCC_ST_PH_A +: 2] = phase_a;
    status_word[SCC_ST_PH_B +: 2] = phase_b;
    status_word[SCC_ST_DAC_A +: 4] = dac_code_a;
    status_word[SCC_ST_DAC_B +: 4] = dac_code_b;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dp_write <= 1'b0;
      dp_reg <= SCC_R_NONE;
    end else begin
      dp_write <= take && hwrite;
      dp_reg <= ap_reg;
    end
  end

  // read data is sampled in the address phase, so a read right
  // behind a write to the same register returns the older value
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      case (ap_reg)
        SCC_R_PERIOD: hrdata <= {16'h0000, period_reg};
        SCC_R_FAST: hrdata <= {16'h0000, fast_reg};
        SCC_R_SERIAL: hrdata <= {22'h000000, serial_reg};
        SCC_R_STATUS: hrdata <= status_word;
        default: hrdata <= 32'h00000000;
      endcase
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      period_reg <= CHOP_PERIOD;
      fast_reg <= SCC_FAST_RST;
      serial_reg <= SCC_SERIAL_RST;
    end else if (dp_write) begin
      case (dp_reg)
        SCC_R_PERIOD: period_reg <= hwdata[15:0];
        SCC_R_FAST: fast_reg <= hwdata[15:0];
        SCC_R_SERIAL: serial_reg <= hwdata[9:0];
        default: period_reg <= period_reg;
      endcase
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_fault_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    (supply_threshold_trip || overtemp_trip) |=> fault_output ##1 fault_output || sleep_s)
    else $error("fault not raised");
  a_fault_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    (fault_output && !sleep_s) |=> fault_output && coil_a_gates == SCC_G_OFF
      && coil_b_gates == SCC_G_OFF)
    else $error("fault or gates not held");
  a_sleep_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    (sleep_s && !supply_threshold_trip && !overtemp_trip) |=> !fault_output && !ocp_flag)
    else $error("sleep did not clear error");
  a_fault_driven: assert property (@(posedge sys_clk) disable iff (!nrst)
    fault_output_oe)
    else $error("fault pin released");
  a_dac_full: assert property (@(posedge sys_clk) disable iff (!nrst)
    standalone |=> dac_code_a == SCC_DAC_FULL && dac_code_b == SCC_DAC_FULL)
    else $error("dac not forced");
  a_standby_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    sleep_s |=> standby_active && coil_a_gates == SCC_G_OFF && coil_b_gates == SCC_G_OFF)
    else $error("gates on in standby");
  a_pol_sync: assert property (@(posedge sys_clk) disable iff (!nrst)
    $changed(bridge_a_polarity) |-> ##2 restart_a)
    else $error("polarity change not seen");
  a_half_offset: assert property (@(posedge sys_clk) disable iff (!nrst)
    (start_a && period_reg == 16'h0010 && $stable(period_reg)) |-> ##8 start_b)
    else $error("bridge offset wrong");
  a_on_dir_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase_a == SCC_ON && !hold_off && !sync2[I_POL_A]) |=> coil_a_gates == SCC_G_ON_FWD)
    else $error("bridge a direction wrong");
  a_on_dir_b: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase_b == SCC_ON && !hold_off && sync2[I_POL_B]) |=> coil_b_gates == SCC_G_ON_REV)
    else $error("bridge b direction wrong");

endmodule

// ### rtl/scc_pkg.sv
// shared constants and types of the stepper chopper control block
// assumes a single 250 MHz system clock and an AHB-Lite register port
package scc_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int unsigned SCC_CLK_HZ = 250_000_000;
  localparam int unsigned SCC_CHOP_HZ = 25_000;
  localparam int unsigned SCC_CHOP_CYCLES = SCC_CLK_HZ / SCC_CHOP_HZ;
  localparam int unsigned SCC_FAST_CYCLES = SCC_CHOP_CYCLES / 4;

  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [7:0] SCC_OFS_PERIOD = 8'h00;
  localparam logic [7:0] SCC_OFS_FAST = 8'h04;
  localparam logic [7:0] SCC_OFS_SERIAL = 8'h08;
  localparam logic [7:0] SCC_OFS_STATUS = 8'h0C;
  localparam logic [15:0] SCC_FAST_RST = 16'(SCC_FAST_CYCLES);
  localparam logic [9:0] SCC_SERIAL_RST = 10'h000;
  localparam logic [3:0] SCC_DAC_FULL = 4'hF;
  // serial control fields
  localparam int SCC_SR_DAC_A = 0;
  localparam int SCC_SR_DAC_B = 4;
  localparam int SCC_SR_MIX_A = 8;
  localparam int SCC_SR_MIX_B = 9;
  // status fields
  localparam int SCC_ST_FAULT = 0;
  localparam int SCC_ST_OCP = 1;
  localparam int SCC_ST_OT = 2;
  localparam int SCC_ST_STBY = 3;
  localparam int SCC_ST_ALONE = 4;
  localparam int SCC_ST_PH_A = 5;
  localparam int SCC_ST_PH_B = 7;
  localparam int SCC_ST_DAC_A = 9;
  localparam int SCC_ST_DAC_B = 13;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {SCC_OFF, SCC_ON, SCC_FAST, SCC_SLOW} scc_phase_type;
  typedef enum logic [2:0] {
    SCC_R_PERIOD, SCC_R_FAST, SCC_R_SERIAL, SCC_R_STATUS, SCC_R_NONE
  } scc_reg_type;
  typedef struct packed {
    logic hi1;
    logic lo1;
    logic hi2;
    logic lo2;
  } scc_gates_type;

  localparam scc_gates_type SCC_G_OFF = 4'h0;
  localparam scc_gates_type SCC_G_ON_FWD = 4'h9;
  localparam scc_gates_type SCC_G_ON_REV = 4'h6;
  localparam scc_gates_type SCC_G_FD_FWD = 4'h4;
  localparam scc_gates_type SCC_G_FD_REV = 4'h1;
  localparam scc_gates_type SCC_G_SLOW = 4'h5;

endpackage

// ### rtl/scc_bridge.sv
// one full bridge chopper: on, fast decay and slow decay phases
// assumes start pulses one per period and inputs already synchronised
`timescale 1ns/1ps
module scc_bridge (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic restart,
  input wire logic polarity,
  input wire logic mixed_en,
  input wire logic sense_trip,
  input wire logic hold_off,
  input wire logic [15:0] fast_len,
  output scc_pkg::scc_gates_type gates,
  output scc_pkg::scc_phase_type phase
);
  import scc_pkg::*;

  logic [15:0] on_cnt;
  logic [15:0] fast_cnt;
  logic [15:0] fast_left;
  logic begin_cycle;

  assign begin_cycle = start | restart;

  // --------------------------------------------------------------
  // phase sequence
  // --------------------------------------------------------------
  // longer on time leaves less fast decay
  always_comb begin
    fast_left = (on_cnt >= fast_len) ? 16'h0000 : 16'(fast_len - on_cnt);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      on_cnt <= 16'h0000;
    end else if (begin_cycle) begin
      on_cnt <= 16'h0000;
    end else if (phase == SCC_ON && on_cnt != 16'hFFFF) begin
      on_cnt <= 16'(on_cnt + 16'h0001);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fast_cnt <= 16'h0000;
    end else if (begin_cycle) begin
      fast_cnt <= 16'h0000;
    end else if (phase == SCC_ON && sense_trip) begin
      fast_cnt <= fast_left;
    end else if (phase == SCC_FAST && fast_cnt != 16'h0000) begin
      fast_cnt <= 16'(fast_cnt - 16'h0001);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= SCC_OFF;
    end else if (hold_off) begin
      phase <= SCC_OFF;
    end else if (begin_cycle) begin
      phase <= sense_trip ? SCC_SLOW : SCC_ON;
    end else begin
      case (phase)
        SCC_ON: begin
          if (sense_trip) begin
            // with mixed decay off the fast phase has zero length
            phase <= (mixed_en && fast_left != 16'h0000) ? SCC_FAST : SCC_SLOW;
          end
        end
        SCC_FAST: begin
          if (fast_cnt <= 16'h0001) begin
            phase <= SCC_SLOW;
          end
        end
        default: phase <= phase;
      endcase
    end
  end

  // --------------------------------------------------------------
  // gate drive
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gates <= SCC_G_OFF;
    end else if (hold_off) begin
      gates <= SCC_G_OFF;
    end else begin
      case (phase)
        SCC_ON: gates <= polarity ? SCC_G_ON_REV : SCC_G_ON_FWD;
        SCC_FAST: gates <= polarity ? SCC_G_FD_REV : SCC_G_FD_FWD;
        SCC_SLOW: gates <= SCC_G_SLOW;
        default: gates <= SCC_G_OFF;
      endcase
    end
  end

  a_slow_gates: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == SCC_SLOW && !hold_off) |=> gates == SCC_G_SLOW)
    else $error("slow decay gates wrong");
  a_fast_gates: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == SCC_FAST && !hold_off) |=> (!gates.hi1 && !gates.hi2
      && gates.lo1 == !$past(polarity) && gates.lo2 == $past(polarity)))
    else $error("fast decay gates wrong");
  a_restart_now: assert property (@(posedge sys_clk) disable iff (!nrst)
    (restart && !hold_off) |=> (phase == SCC_ON || phase == SCC_SLOW) && on_cnt == 16'h0000)
    else $error("restart not immediate");
  a_tripped_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    (begin_cycle && sense_trip && !hold_off) |=> phase == SCC_SLOW ##1 gates == SCC_G_SLOW)
    else $error("on phase after tripped start");
  a_on_end: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == SCC_ON && sense_trip && !begin_cycle && !hold_off) |=> phase != SCC_ON)
    else $error("on phase not ended");
  a_mixed_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (phase == SCC_ON && sense_trip && !mixed_en && !begin_cycle && !hold_off)
      |=> phase == SCC_SLOW)
    else $error("fast decay with mixed off");

endmodule

// ### tb/scc_ctrl_model.sv
// motion controller model driving the polarity and mixed decay pins
// assumes the bench gives step commands on rising edges of sys_clk
`timescale 1ns/1ps
module scc_ctrl_model (
  input wire logic sys_clk,
  input wire logic pol_a_cmd,
  input wire logic pol_b_cmd,
  input wire logic mix_cmd,
  input wire logic moving,
  input wire logic falling,
  output logic bridge_a_polarity,
  output logic bridge_b_polarity,
  output logic bridge_a_mixed_decay_n,
  output logic bridge_b_mixed_decay_n
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  initial begin
    bridge_a_polarity = 1'b0;
    bridge_b_polarity = 1'b0;
    bridge_a_mixed_decay_n = 1'b1;
    bridge_b_mixed_decay_n = 1'b1;
  end
  // mixed decay only while moving on a falling half-wave; the pin is low active
  always @(posedge sys_clk) begin
    bridge_a_polarity <= pol_a_cmd;
    bridge_b_polarity <= pol_b_cmd;
    bridge_a_mixed_decay_n <= !(mix_cmd && moving && falling);
    bridge_b_mixed_decay_n <= !(mix_cmd && moving && falling);
  end
endmodule

// ### tb/scc_top_bench.sv
// self-checking bench of the chopper block with a controller model
// assumes chopper period shortened to 16 cycles
`timescale 1ns/1ps
module scc_top_bench;
  import scc_pkg::*;
  // short period keeps the chopper rate high while mixed decay stays on
  localparam logic [15:0] P = 16'h0010;
  logic sys_clk, nrst, hsel, hwrite, hreadyout, hresp, interface_select, sleep_request;
  logic sense_a_input, sense_b_input, supply_threshold_trip, overtemp_trip;
  logic pol_a_cmd, pol_b_cmd, mix_cmd, moving, falling;
  logic pol_a, pol_b, mix_a_n, mix_b_n, fault_output, fault_output_oe, standby_active;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] dac_code_a, dac_code_b;
  scc_gates_type coil_a_gates, coil_b_gates;
  int n_mismatch, check_count;
  // ----------------------------------------
  // instances
  // ----------------------------------------
  scc_ctrl_model ctrl_u (.sys_clk(sys_clk), .pol_a_cmd(pol_a_cmd), .pol_b_cmd(pol_b_cmd),
    .mix_cmd(mix_cmd), .moving(moving), .falling(falling), .bridge_a_polarity(pol_a),
    .bridge_b_polarity(pol_b), .bridge_a_mixed_decay_n(mix_a_n),
    .bridge_b_mixed_decay_n(mix_b_n));
  scc_top #(.CHOP_PERIOD(P)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .interface_select(interface_select), .bridge_a_mixed_decay_n(mix_a_n),
    .bridge_b_mixed_decay_n(mix_b_n), .bridge_a_polarity(pol_a), .bridge_b_polarity(pol_b),
    .sleep_request(sleep_request), .sense_a_input(sense_a_input),
    .sense_b_input(sense_b_input), .supply_threshold_trip(supply_threshold_trip),
    .overtemp_trip(overtemp_trip), .coil_a_gates(coil_a_gates), .coil_b_gates(coil_b_gates),
    .fault_output(fault_output), .fault_output_oe(fault_output_oe),
    .standby_active(standby_active), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // hready is sampled before this edge's updates land, as the bus defines it
  task automatic wait_hready;
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (hreadyout !== 1'b1 && i < 32);
    if (i >= 32) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_hready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_hready();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask
  task automatic wait_gates(input logic b, input scc_gates_type g, input int lim);
    int i;
    i = 0;
    do begin
      @(negedge sys_clk);
      i++;
    end while ((b ? coil_b_gates : coil_a_gates) !== g && i < lim);
    chk(b ? "coil b gates" : "coil a gates", 32'(b ? coil_b_gates : coil_a_gates), 32'(g));
    // a match on the last poll is not a timeout; only a real miss ends the run
    if ((b ? coil_b_gates : coil_a_gates) !== g) complete_run();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_reset;
    logic [31:0] rd;
    chk("fault oe", 32'(fault_output_oe), 32'h1);
    chk("fault", 32'(fault_output), 32'h0);
    chk("dac a", 32'(dac_code_a), 32'(SCC_DAC_FULL));
    chk("dac b", 32'(dac_code_b), 32'(SCC_DAC_FULL));
    ahb(1'b0, 32'(SCC_OFS_PERIOD), 32'h0, rd);
    chk("period", rd, 32'(P));
    ahb(1'b0, 32'(SCC_OFS_FAST), 32'h0, rd);
    chk("fast", rd, 32'(SCC_FAST_RST));
    ahb(1'b0, 32'h0000_0040, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    ahb(1'b0, 32'(SCC_OFS_STATUS), 32'h0, rd);
    chk("standalone", 32'(rd[SCC_ST_ALONE]), 32'h1);
    $display("done: reset");
  endtask
  task automatic test_drive;
    int hits;
    hits = 0;
    wait_gates(1'b0, SCC_G_ON_FWD, 40);
    wait_gates(1'b1, SCC_G_ON_FWD, 40);
    @(posedge sys_clk);
    sense_a_input <= 1'b1;
    wait_gates(1'b0, SCC_G_SLOW, 6);
    // sense held tripped across 40 cycles, two and a half periods: no on phase may start
    for (int i = 0; i < 40; i++) begin
      @(negedge sys_clk);
      if (coil_a_gates === SCC_G_ON_FWD) hits++;
    end
    chk("on while tripped", 32'(hits), 32'h0);
    @(posedge sys_clk);
    pol_a_cmd <= 1'b1;
    pol_b_cmd <= 1'b1;
    sense_a_input <= 1'b0;
    wait_gates(1'b0, SCC_G_ON_REV, 10);
    wait_gates(1'b1, SCC_G_ON_REV, 10);
    $display("done: drive");
  endtask
  task automatic test_fast;
    logic [31:0] rd;
    mix_cmd <= 1'b1;
    moving <= 1'b1;
    falling <= 1'b1;
    ahb(1'b1, 32'(SCC_OFS_FAST), 32'h0000_0008, rd);
    for (int k = 0; k < 2; k++) begin
      wait_gates(k[0], SCC_G_ON_REV, 40);
      @(posedge sys_clk);
      if (k == 0) sense_a_input <= 1'b1;
      else sense_b_input <= 1'b1;
      wait_gates(k[0], SCC_G_FD_REV, 6);
      wait_gates(k[0], SCC_G_SLOW, 16);
    end
    moving <= 1'b0;
    $display("done: fast decay");
  endtask
  task automatic test_fault;
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      if (k == 0) overtemp_trip <= 1'b1;
      else supply_threshold_trip <= 1'b1;
      @(posedge sys_clk);
      overtemp_trip <= 1'b0;
      supply_threshold_trip <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("fault set", 32'(fault_output), 32'h1);
      wait_gates(1'b0, SCC_G_OFF, 4);
      repeat (20) @(negedge sys_clk);
      chk("fault held", 32'(fault_output), 32'h1);
      @(posedge sys_clk);
      sleep_request <= 1'b1;
      repeat (6) @(negedge sys_clk);
      chk("fault cleared", 32'(fault_output), 32'h0);
      chk("standby", 32'(standby_active), 32'h1);
      chk("gates in standby", 32'(coil_b_gates), 32'(SCC_G_OFF));
      @(posedge sys_clk);
      sleep_request <= 1'b0;
    end
    $display("done: fault");
  endtask
  task automatic test_serial;
    logic [31:0] rd;
    interface_select <= 1'b1;
    ahb(1'b1, 32'(SCC_OFS_SERIAL), 32'h0000_00A5, rd);
    repeat (4) @(negedge sys_clk);
    chk("serial dac a", 32'(dac_code_a), 32'h5);
    chk("serial dac b", 32'(dac_code_b), 32'hA);
    @(posedge sys_clk);
    interface_select <= 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("alone dac a", 32'(dac_code_a), 32'(SCC_DAC_FULL));
    $display("done: serial");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {nrst, hsel, hwrite, interface_select, sleep_request, sense_a_input} = '0;
    {sense_b_input, supply_threshold_trip, overtemp_trip, pol_a_cmd, pol_b_cmd} = '0;
    {mix_cmd, moving, falling, haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    n_mismatch = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    test_reset();
    test_drive();
    test_fast();
    test_fault();
    test_serial();
    complete_run();
  end
endmodule
